// [core/exec_alu.v]
// Purpose: combinational result and flag datapath
// Assumes: operands are stable during the execute cycle
// Notes: flags out are the next values; unaffected flags pass through
`timescale 1ns/1ps
`default_nettype none
`include "exec_subset_defines.vh"
module exec_alu (
  input  wire [4:0] op,
  input  wire [7:0] wreg,
  input  wire [7:0] mem,
  input  wire [7:0] imm,
  input  wire [2:0] bit_sel,
  input  wire       c_in,
  input  wire       z_in,
  input  wire       ac_in,
  input  wire       ov_in,
  output reg  [7:0] result,
  output reg        c_out,
  output reg        z_out,
  output reg        ac_out,
  output reg        ov_out
);
  reg [8:0] diff;
  reg [4:0] ldiff;
  always @* begin
    diff   = {1'b0, wreg} - {1'b0, mem} - {8'h00, ~c_in};
    ldiff  = {1'b0, wreg[3:0]} - {1'b0, mem[3:0]} - {4'h0, ~c_in};
    result = 8'h00;
    c_out  = c_in;
    z_out  = z_in;
    ac_out = ac_in;
    ov_out = ov_in;
    case (op)
      `OP_INC, `OP_INCA: begin
        result = mem + 8'h01;
        z_out  = (result == 8'h00);
      end
      `OP_MOV_AM:  result = mem;
      `OP_MOV_AX:  result = imm;
      `OP_MOV_MA:  result = wreg;
      `OP_OR_AM, `OP_ORM: begin
        result = wreg | mem;
        z_out  = (result == 8'h00);
      end
      `OP_OR_AX: begin
        result = wreg | imm;
        z_out  = (result == 8'h00);
      end
      `OP_RET_AX:  result = imm;
      `OP_RL, `OP_RLA: result = {mem[6:0], mem[7]};
      `OP_RLC, `OP_RLCA: begin
        result = {mem[6:0], c_in};
        c_out  = mem[7];
      end
      `OP_RR, `OP_RRA: result = {mem[0], mem[7:1]};
      `OP_RRC, `OP_RRCA: begin
        result = {c_in, mem[7:1]};
        c_out  = mem[0];
      end
      `OP_SUBB, `OP_SUBBM: begin
        result = diff[7:0];
        c_out  = ~diff[8];
        ac_out = ~ldiff[4];
        ov_out = (wreg[7] ^ mem[7]) & (wreg[7] ^ diff[7]);
        z_out  = (diff[7:0] == 8'h00);
      end
      `OP_DSKIP, `OP_DSKIPA: result = mem - 8'h01;
      `OP_ISKIP, `OP_ISKIPA: result = mem + 8'h01;
      `OP_SET:    result = 8'hFF;
      `OP_SETBIT: result = mem | (8'h01 << bit_sel);
      default:    result = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// [core/exec_subset.v]
// Purpose: execute stage for a subset of an 8-bit instruction set
// Assumes: memory read data valid in the cycle instr_valid is high
// Notes: one machine cycle per instruction, a dummy cycle follows
//        jumps, returns and taken skips
//        flag writes are masked per instruction
`timescale 1ns/1ps
`default_nettype none
`include "exec_subset_defines.vh"
module exec_subset (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        instr_valid,
  input  wire [4:0]  opcode,
  input  wire [7:0]  mem_addr,
  input  wire [7:0]  imm_data,
  input  wire [2:0]  bit_sel,
  input  wire [10:0] jump_addr,
  input  wire [7:0]  mem_rdata,
  input  wire [10:0] stack_top,
  input  wire        irq_pending,
  output reg         busy,
  output reg  [10:0] pc,
  output reg         stack_pop,
  output reg         mem_we,
  output reg  [7:0]  mem_waddr,
  output reg  [7:0]  mem_wdata,
  output reg  [7:0]  working_register,
  output reg         carry_flag,
  output reg         zero_flag,
  output reg         nibble_carry_flag,
  output reg         signed_range_flag,
  output reg         global_irq_enable,
  output reg         irq_taken
);
  // Dummy cycle follows jumps, returns and taken skips
  localparam ST_EXEC  = 1'b0;
  localparam ST_DUMMY = 1'b1;

  reg       state_q;
  reg       state_d;
  reg [7:0] alu_result;
  reg       c_n;
  reg       z_n;
  reg       ac_n;
  reg       ov_n;
  wire [7:0] res_w;
  wire       c_w;
  wire       z_w;
  wire       ac_w;
  wire       ov_w;
  // Next values of the output registers
  reg [10:0] pc_seq;
  reg [10:0] pc_d;
  reg        stack_pop_d;
  reg        mem_we_d;
  reg [7:0]  mem_waddr_d;
  reg [7:0]  mem_wdata_d;
  reg [7:0]  wreg_d;
  reg        carry_d;
  reg        zero_d;
  reg        nibble_d;
  reg        range_d;
  reg        irq_en_d;
  reg        irq_taken_d;
  reg [3:0]  flag_wr;

  // Datapath results, named for the register logic
  always @* begin
    alu_result = res_w;
    c_n  = c_w;
    z_n  = z_w;
    ac_n = ac_w;
    ov_n = ov_w;
  end

  // Result and flag datapath
  exec_alu u_alu (
    .op      (opcode),
    .wreg    (working_register),
    .mem     (mem_rdata),
    .imm     (imm_data),
    .bit_sel (bit_sel),
    .c_in    (carry_flag),
    .z_in    (zero_flag),
    .ac_in   (nibble_carry_flag),
    .ov_in   (signed_range_flag),
    .result  (res_w),
    .c_out   (c_w),
    .z_out   (z_w),
    .ac_out  (ac_w),
    .ov_out  (ov_w)
  );

  // Result destined for the working register
  function to_wreg;
    input [4:0] op;
    begin
      case (op)
        `OP_INCA:   to_wreg = 1'b1;
        `OP_MOV_AM: to_wreg = 1'b1;
        `OP_MOV_AX: to_wreg = 1'b1;
        `OP_OR_AM:  to_wreg = 1'b1;
        `OP_OR_AX:  to_wreg = 1'b1;
        `OP_RET_AX: to_wreg = 1'b1;
        `OP_RLA:    to_wreg = 1'b1;
        `OP_RLCA:   to_wreg = 1'b1;
        `OP_RRA:    to_wreg = 1'b1;
        `OP_RRCA:   to_wreg = 1'b1;
        `OP_SUBB:   to_wreg = 1'b1;
        `OP_DSKIPA: to_wreg = 1'b1;
        `OP_ISKIPA: to_wreg = 1'b1;
        default:    to_wreg = 1'b0;
      endcase
    end
  endfunction

  // Result destined for data memory
  function to_mem;
    input [4:0] op;
    begin
      case (op)
        `OP_INC:    to_mem = 1'b1;
        `OP_MOV_MA: to_mem = 1'b1;
        `OP_ORM:    to_mem = 1'b1;
        `OP_RL:     to_mem = 1'b1;
        `OP_RLC:    to_mem = 1'b1;
        `OP_RR:     to_mem = 1'b1;
        `OP_RRC:    to_mem = 1'b1;
        `OP_SUBBM:  to_mem = 1'b1;
        `OP_DSKIP:  to_mem = 1'b1;
        `OP_SET:    to_mem = 1'b1;
        `OP_SETBIT: to_mem = 1'b1;
        `OP_ISKIP:  to_mem = 1'b1;
        default:    to_mem = 1'b0;
      endcase
    end
  endfunction

  // Flags that an instruction may change: carry, zero, nibble, range
  function [3:0] flag_mask;
    input [4:0] op;
    begin
      case (op)
        `OP_INC, `OP_INCA:    flag_mask = 4'h4;
        `OP_OR_AM, `OP_OR_AX: flag_mask = 4'h4;
        `OP_ORM:              flag_mask = 4'h4;
        `OP_RLC, `OP_RLCA:    flag_mask = 4'h8;
        `OP_RRC, `OP_RRCA:    flag_mask = 4'h8;
        `OP_SUBB, `OP_SUBBM:  flag_mask = 4'hF;
        default:              flag_mask = 4'h0;
      endcase
    end
  endfunction

  // Zero-test skip instructions
  function is_skip;
    input [4:0] op;
    begin
      case (op)
        `OP_DSKIP:  is_skip = 1'b1;
        `OP_DSKIPA: is_skip = 1'b1;
        `OP_ISKIP:  is_skip = 1'b1;
        `OP_ISKIPA: is_skip = 1'b1;
        default: is_skip = 1'b0;
      endcase
    end
  endfunction

  // Instructions that pop the return stack
  function is_return;
    input [4:0] op;
    begin
      case (op)
        `OP_RET:    is_return = 1'b1;
        `OP_RET_AX: is_return = 1'b1;
        `OP_IRET:   is_return = 1'b1;
        default: is_return = 1'b0;
      endcase
    end
  endfunction

  // Requests during the dummy cycle are ignored
  wire exec_now   = instr_valid && (state_q == ST_EXEC);
  wire skip_taken = is_skip(opcode) && (alu_result == 8'h00);
  wire pc_change  = (opcode == `OP_JMP) || is_return(opcode);
  wire long_op    = skip_taken || pc_change;

  // Long instructions spend one extra cycle in the dummy state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_EXEC: begin
        if (exec_now && long_op) begin
          state_d = ST_DUMMY;
        end else begin
          state_d = ST_EXEC;
        end
      end
      ST_DUMMY: state_d = ST_EXEC;
      default:  state_d = ST_EXEC;
    endcase
  end

  // Sequential successor: two steps when a skip is taken
  always @* begin
    if (skip_taken) begin
      pc_seq = pc + 11'h002;
    end else begin
      pc_seq = pc + 11'h001;
    end
  end

  // Flags and data move only on an accepted instruction
  always @* begin
    flag_wr     = 4'h0;
    carry_d     = carry_flag;
    zero_d      = zero_flag;
    nibble_d    = nibble_carry_flag;
    range_d     = signed_range_flag;
    wreg_d      = working_register;
    mem_we_d    = 1'b0;
    mem_waddr_d = mem_waddr;
    mem_wdata_d = mem_wdata;
    if (exec_now) begin
      flag_wr = flag_mask(opcode);
      // Unlisted flags hold even if the datapath disturbs them
      if (flag_wr[3]) begin
        carry_d = c_n;
      end
      if (flag_wr[2]) begin
        zero_d = z_n;
      end
      if (flag_wr[1]) begin
        nibble_d = ac_n;
      end
      if (flag_wr[0]) begin
        range_d = ov_n;
      end
      if (to_wreg(opcode)) begin
        wreg_d = alu_result;
      end
      if (to_mem(opcode)) begin
        mem_we_d    = 1'b1;
        mem_waddr_d = mem_addr;
        mem_wdata_d = alu_result;
      end
    end
  end

  // Program flow: counter, stack pop, interrupt enable and diversion
  always @* begin
    pc_d        = pc;
    stack_pop_d = 1'b0;
    irq_en_d    = global_irq_enable;
    irq_taken_d = 1'b0;
    if (exec_now) begin
      case (opcode)
        `OP_JMP: begin
          pc_d = jump_addr;
        end
        `OP_RET, `OP_RET_AX: begin
          pc_d        = stack_top;
          stack_pop_d = 1'b1;
        end
        `OP_IRET: begin
          stack_pop_d = 1'b1;
          irq_en_d    = 1'b1;
          // A pending request is served in place of the popped address
          if (irq_pending) begin
            pc_d        = `IRQ_VECTOR;
            irq_taken_d = 1'b1;
          end else begin
            pc_d = stack_top;
          end
        end
        default: begin
          pc_d = pc_seq;
        end
      endcase
    end
  end

  // Output registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q           <= ST_EXEC;
      busy              <= 1'b0;
      pc                <= `PC_RESET;
      stack_pop         <= 1'b0;
      mem_we            <= 1'b0;
      mem_waddr         <= 8'h00;
      mem_wdata         <= 8'h00;
      working_register  <= `WREG_RESET;
      carry_flag        <= 1'b0;
      zero_flag         <= 1'b0;
      nibble_carry_flag <= 1'b0;
      signed_range_flag <= 1'b0;
      global_irq_enable <= 1'b0;
      irq_taken         <= 1'b0;
    end else begin
      state_q           <= state_d;
      busy              <= (state_d == ST_DUMMY);
      pc                <= pc_d;
      stack_pop         <= stack_pop_d;
      mem_we            <= mem_we_d;
      mem_waddr         <= mem_waddr_d;
      mem_wdata         <= mem_wdata_d;
      working_register  <= wreg_d;
      carry_flag        <= carry_d;
      zero_flag         <= zero_d;
      nibble_carry_flag <= nibble_d;
      signed_range_flag <= range_d;
      global_irq_enable <= irq_en_d;
      irq_taken         <= irq_taken_d;
    end
  end
endmodule
`default_nettype wire

// [core/exec_subset_defines.vh]
// Purpose: constants for the instruction execute subset
// Assumes: 8-bit data, 11-bit program counter, 8-bit data address
// Notes: opcode values are local encodings of this block
`ifndef EXEC_SUBSET_DEFINES_VH
`define EXEC_SUBSET_DEFINES_VH
`define OP_NOP      5'h00
`define OP_INC      5'h01
`define OP_INCA     5'h02
`define OP_JMP      5'h03
`define OP_MOV_AM   5'h04
`define OP_MOV_AX   5'h05
`define OP_MOV_MA   5'h06
`define OP_OR_AM    5'h07
`define OP_OR_AX    5'h08
`define OP_ORM      5'h09
`define OP_RET      5'h0A
`define OP_RET_AX   5'h0B
`define OP_IRET     5'h0C
`define OP_RL       5'h0D
`define OP_RLA      5'h0E
`define OP_RLC      5'h0F
`define OP_RLCA     5'h10
`define OP_RR       5'h11
`define OP_RRA      5'h12
`define OP_RRC      5'h13
`define OP_RRCA     5'h14
`define OP_SUBB     5'h15
`define OP_SUBBM    5'h16
`define OP_DSKIP    5'h17
`define OP_DSKIPA   5'h18
`define OP_SET      5'h19
`define OP_SETBIT   5'h1A
`define OP_ISKIP    5'h1B
`define OP_ISKIPA   5'h1C
`define OP_WIDTH    5
`define PC_WIDTH    11
`define WREG_RESET  8'h00
`define PC_RESET    11'h000
`define IRQ_VECTOR  11'h004
`endif

// [verification/exec_chk_asserts.sv]
// Purpose: port checker for exec_subset
// Assumes: local opcode encodings
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
`include "exec_subset_defines.vh"
module exec_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [4:0]  opcode,
  input wire logic [7:0]  mem_rdata,
  input wire logic [10:0] stack_top,
  input wire logic [10:0] jump_addr,
  input wire logic        irq_pending,
  input wire logic        busy,
  input wire logic [10:0] pc,
  input wire logic        stack_pop,
  input wire logic        mem_we,
  input wire logic [7:0]  mem_wdata,
  input wire logic        zero_flag,
  input wire logic        irq_taken
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire tk = instr_valid && !busy;
  // Pop pulse in the dummy cycle, both gone a cycle later
  sequence s_pop;
    stack_pop && busy ##1 !stack_pop && !busy;
  endsequence
  // Dummy cycle that closes a two-cycle instruction
  sequence s_dummy;
    busy ##1 !busy;
  endsequence
  a_jump_two: assert property (
    tk && opcode == `OP_JMP |=> pc == $past(jump_addr) ##0 s_dummy)
    else $error("bad jump");
  a_busy_refuse: assert property (
    instr_valid && busy |=> !mem_we && !stack_pop)
    else $error("bad refusal");
  a_ret_pop: assert property (
    tk && opcode == `OP_RET |=> pc == $past(stack_top) ##0 s_pop)
    else $error("bad return");
  a_irq_divert: assert property (
    tk && opcode == `OP_IRET && irq_pending |=> irq_taken && pc == `IRQ_VECTOR)
    else $error("bad divert");
  a_skip_taken: assert property (
    tk && opcode == `OP_ISKIP && mem_rdata == 8'hFF
    |=> busy && mem_wdata == 8'h00 && pc == $past(pc) + 11'h002)
    else $error("bad taken skip");
  a_skip_not: assert property (
    tk && opcode == `OP_DSKIP && mem_rdata != 8'h01
    |=> !busy && mem_we && pc == $past(pc) + 11'h001)
    else $error("bad untaken skip");
  a_set_byte: assert property (
    tk && opcode == `OP_SET |=> mem_we && mem_wdata == 8'hFF && $stable(zero_flag))
    else $error("bad set");
  a_nop_still: assert property (
    tk && opcode == `OP_NOP |=> !mem_we && !busy && $stable(zero_flag))
    else $error("bad nop");
  a_inc_zero: assert property (
    tk && opcode == `OP_INC
    |=> mem_wdata == $past(mem_rdata) + 8'h01 && zero_flag == (mem_wdata == 8'h00))
    else $error("bad increment");
endmodule
`default_nettype wire

// [verification/exec_mem_model.sv]
// Purpose: data memory and return stack model
// Assumes: reads answer in the same cycle
// Notes: stack alternates two fixed entries
`timescale 1ns/1ps
`default_nettype none
module exec_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_we,
  input  wire logic        stack_pop,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [7:0]  mem_waddr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  output logic      [10:0] stack_top
);
  logic [7:0] mem [0:255];
  logic       sp_q = 1'b0;
  assign mem_rdata = mem[mem_addr];
  assign stack_top = sp_q ? 11'h2AA : 11'h155;
  always @(posedge clk) begin
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;
    if (stack_pop)
      sp_q <= ~sp_q;
  end
endmodule
`default_nettype wire

// [verification/exec_subset_tb_top.sv]
// Purpose: self-checking bench for exec_subset
// Assumes: operand address 8'h2A, then 8'h3C from t_rot on, preset per op
// Notes: watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none
`include "exec_subset_defines.vh"
module exec_subset_tb_top;
  logic        clk, rst_n, instr_valid, irq_pending, busy, stack_pop, mem_we, irq_taken;
  logic        carry_flag, zero_flag, nibble_carry_flag, signed_range_flag, global_irq_enable;
  logic [4:0]  opcode;
  logic [2:0]  bit_sel;
  logic [7:0]  mem_addr, imm_data, mem_rdata, mem_waddr, mem_wdata, working_register;
  logic [10:0] jump_addr, stack_top, pc, p0;
  int          errors, cmp_count;
  exec_subset dut_u (
    .clk               (clk),
    .rst_n             (rst_n),
    .instr_valid       (instr_valid),
    .opcode            (opcode),
    .mem_addr          (mem_addr),
    .imm_data          (imm_data),
    .bit_sel           (bit_sel),
    .jump_addr         (jump_addr),
    .mem_rdata         (mem_rdata),
    .stack_top         (stack_top),
    .irq_pending       (irq_pending),
    .busy              (busy),
    .pc                (pc),
    .stack_pop         (stack_pop),
    .mem_we            (mem_we),
    .mem_waddr         (mem_waddr),
    .mem_wdata         (mem_wdata),
    .working_register  (working_register),
    .carry_flag        (carry_flag),
    .zero_flag         (zero_flag),
    .nibble_carry_flag (nibble_carry_flag),
    .signed_range_flag (signed_range_flag),
    .global_irq_enable (global_irq_enable),
    .irq_taken         (irq_taken)
  );
  exec_mem_model mdl_u (
    .clk       (clk),
    .mem_we    (mem_we),
    .stack_pop (stack_pop),
    .mem_addr  (mem_addr),
    .mem_waddr (mem_waddr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata),
    .stack_top (stack_top)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input string n, input logic [19:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task summarize;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task ex(input logic [4:0] o, input logic [7:0] x);
    @(posedge clk) #1;
    mdl_u.mem[mem_addr] = x;
    p0 = pc;
    opcode = o;
    imm_data = x;
    instr_valid = 1'b1;
    @(posedge clk) #1;
    instr_valid = 1'b0;
  endtask
  // Result word: busy, write, data, carry, zero, nibble, range
  task dx(input logic [4:0] o, input logic [7:0] x, input logic [19:0] e, p);
    ex(o, x);
    chk("data", {busy, mem_we, mem_we ? mem_wdata : working_register,
      carry_flag, zero_flag, nibble_carry_flag, signed_range_flag}, e);
    chk("pc", 11'(pc - p0), p);
    if (mem_we) chk("addr", mem_waddr, mem_addr);
  endtask
  task t_alu;
    dx(`OP_INC, 8'hFF, 20'h1004, 1);
    dx(`OP_INCA, 8'h05, 20'h0060, 1);
    dx(`OP_MOV_AX, 8'h10, 20'h0100, 1);
    dx(`OP_SUBB, 8'h05, 20'h00A8, 1);
    dx(`OP_SUBBM, 8'h0A, 20'h100E, 1);
    dx(`OP_SUBB, 8'h80, 20'h08A3, 1);
    dx(`OP_MOV_AX, 8'h00, 20'h0003, 1);
    dx(`OP_OR_AX, 8'h00, 20'h0007, 1);
    dx(`OP_OR_AM, 8'hC3, 20'h0C33, 1);
    dx(`OP_ORM, 8'h0C, 20'h1CF3, 1);
    dx(`OP_MOV_MA, 8'h00, 20'h1C33, 1);
  endtask
  task t_rot;
    mem_addr = 8'h3C;
    dx(`OP_RLA, 8'h81, 20'h0033, 1);
    dx(`OP_RL, 8'h81, 20'h1033, 1);
    dx(`OP_RR, 8'h81, 20'h1C03, 1);
    dx(`OP_RLC, 8'h80, 20'h100B, 1);
    dx(`OP_RRCA, 8'h00, 20'h0803, 1);
  endtask
  task t_skip;
    dx(`OP_SET, 8'h00, 20'h1FF3, 1);
    dx(`OP_SETBIT, 8'hA0, 20'h1A83, 1);
    dx(`OP_NOP, 8'h00, 20'h0803, 1);
    dx(`OP_ISKIP, 8'hFF, 20'h3003, 2);
    dx(`OP_ISKIPA, 8'h05, 20'h0063, 1);
    dx(`OP_DSKIP, 8'h01, 20'h3003, 2);
    dx(`OP_DSKIPA, 8'h01, 20'h2003, 2);
    dx(`OP_DSKIP, 8'h03, 20'h1023, 1);
  endtask
  task t_flow;
    ex(`OP_JMP, 8'h00);
    chk("jmp", {busy, pc}, {1'b1, 11'h5A5});
    ex(`OP_RET, 8'h00);
    chk("ret", {busy, pc}, {1'b1, 11'h155});
    ex(`OP_RET_AX, 8'h3C);
    chk("retx", {working_register, pc}, {8'h3C, 11'h2AA});
    ex(`OP_IRET, 8'h00);
    chk("iret", {global_irq_enable, irq_taken, pc}, {2'b10, 11'h155});
    irq_pending = 1'b1;
    ex(`OP_IRET, 8'h00);
    chk("irq", {irq_taken, pc}, {1'b1, 11'h004});
    irq_pending = 1'b0;
  endtask
  // Request held into the dummy cycle after a jump is ignored
  task t_busy;
    @(posedge clk) #1;
    opcode = `OP_JMP;
    instr_valid = 1'b1;
    @(posedge clk) #1;
    opcode = `OP_SET;
    @(posedge clk) #1;
    instr_valid = 1'b0;
    chk("refuse", {busy, mem_we, pc}, {2'b00, 11'h5A5});
  endtask
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    irq_pending = 1'b0;
    opcode = `OP_NOP;
    mem_addr = 8'h2A;
    imm_data = 8'h00;
    bit_sel = 3'h3;
    jump_addr = 11'h5A5;
    errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    t_alu;
    t_rot;
    t_skip;
    t_flow;
    t_busy;
    summarize;
  end
  initial begin
    #100000;
    errors++;
    summarize;
  end
endmodule
bind exec_subset exec_chk chk_u (
  .clk         (clk),
  .rst_n       (rst_n),
  .instr_valid (instr_valid),
  .opcode      (opcode),
  .mem_rdata   (mem_rdata),
  .stack_top   (stack_top),
  .jump_addr   (jump_addr),
  .irq_pending (irq_pending),
  .busy        (busy),
  .pc          (pc),
  .stack_pop   (stack_pop),
  .mem_we      (mem_we),
  .mem_wdata   (mem_wdata),
  .zero_flag   (zero_flag),
  .irq_taken   (irq_taken)
);
`default_nettype wire
